// file: hdl/sam_addr_data_shift.sv
`timescale 1ns/1ns
`include "sam_defs.svh"
module sam_addr_data_shift (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_smb_enable,
    input wire logic i_byte_done_flag,
    input wire logic i_start_det,
    input wire logic i_stop_det,
    input wire logic i_transmit,
    input wire logic i_arb_lost,
    input wire logic i_sw_ack,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    output logic o_addr_match,
    output logic o_ack_slot,
    output logic [3:0] o_bit_count
);

    logic [7:0] shift_data_byte;
    logic [7:0] address_mask_register;
    logic [7:0] slave_address_register;
    logic [3:0] bit_cnt;
    logic lost;
    logic tx_low;
    logic ack_window;
    logic addr_match;
    logic [7:0] rdata;
    sam_pkg::sam_phase_t phase;
    sam_pkg::sam_phase_t next_phase;
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    sam_pin_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_pin({i_sda, i_scl}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // decode and field selection
    wire sda_s = pin_level[1];
    wire scl_rise = pin_rise[0];
    wire scl_fall = pin_fall[0];
    wire sel_data = i_sfr_addr == `SAM_ADDR_DATA;
    wire sel_mask = i_sfr_addr == `SAM_ADDR_MASK;
    wire sel_slv = i_sfr_addr == `SAM_ADDR_SLV;
    wire data_open = i_byte_done_flag | ~i_smb_enable;
    wire data_wr = i_sfr_wr & sel_data & data_open;
    wire [6:0] addr_compare_mask =
        address_mask_register[`SAM_ADDR_MSB:`SAM_ADDR_LSB];
    wire hw_ack_enable = address_mask_register[`SAM_HWACK_BIT];
    wire [6:0] own_slave_address =
        slave_address_register[`SAM_ADDR_MSB:`SAM_ADDR_LSB];
    wire general_call_enable = slave_address_register[`SAM_GC_BIT];
    wire [6:0] rx_addr = shift_data_byte[`SAM_ADDR_MSB:`SAM_ADDR_LSB];
    wire mask_hit =
        ~|((rx_addr ^ own_slave_address) & addr_compare_mask);
    wire gc_hit = general_call_enable & ~|rx_addr;
    wire at_slot = bit_cnt == `SAM_ACK_SLOT;
    wire in_byte = phase == sam_pkg::sam_addr | phase == sam_pkg::sam_data;
    wire tx_en = i_transmit & ~lost & ~i_arb_lost;
    // stop shifting the register while the byte-done flag is up; a software write still loads it
    wire shift_en = i_smb_enable & ~i_byte_done_flag & scl_rise
        & in_byte & ~at_slot;
    wire hw_ack_val = phase == sam_pkg::sam_addr ? addr_match
        : (phase == sam_pkg::sam_data & i_sw_ack);
    wire sw_ack_val = i_sw_ack & in_byte;
    wire ack_val = ~i_transmit & (hw_ack_enable ? hw_ack_val : sw_ack_val);
    wire [7:0] next_rdata = sel_data ? shift_data_byte
        : sel_mask ? address_mask_register
        : sel_slv ? slave_address_register : 8'h00;

    // byte phase
    always_comb
    begin
        next_phase = phase;
        case (phase)
            sam_pkg::sam_idle:
                next_phase = phase;
            sam_pkg::sam_addr:
                if (scl_rise & at_slot)
                begin
                    next_phase = (addr_match | i_transmit | lost)
                        ? sam_pkg::sam_data : sam_pkg::sam_ignore;
                end
            sam_pkg::sam_data:
                next_phase = phase;
            sam_pkg::sam_ignore:
                next_phase = phase;
            default:
                next_phase = sam_pkg::sam_idle;
        endcase
        if (i_start_det)
        begin
            next_phase = sam_pkg::sam_addr;
        end
        else if (i_stop_det | ~i_smb_enable)
        begin
            next_phase = sam_pkg::sam_idle;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            phase <= sam_pkg::sam_idle;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    // config registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            address_mask_register <= `SAM_MASK_RST;
            slave_address_register <= `SAM_SLV_RST;
        end
        else
        begin
            if (i_sfr_wr & sel_mask)
            begin
                address_mask_register <= i_sfr_wdata;
            end
            if (i_sfr_wr & sel_slv)
            begin
                slave_address_register <= i_sfr_wdata;
            end
        end
    end

    // shift register, msb out, bus sampled in at lsb
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            shift_data_byte <= `SAM_DATA_RST;
        end
        else if (data_wr)
        begin
            shift_data_byte <= i_sfr_wdata;
        end
        else if (shift_en)
        begin
            shift_data_byte <= {shift_data_byte[6:0], sda_s};
        end
    end

    // bit counter, 8 is the acknowledge slot
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst | i_start_det | i_stop_det)
        begin
            bit_cnt <= 4'h0;
        end
        else if (scl_rise & phase != sam_pkg::sam_idle)
        begin
            bit_cnt <= at_slot ? 4'h0 : 4'(bit_cnt + `SAM_BIT_ONE);
        end
    end

    // address match captured at the slot
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst | i_start_det)
        begin
            addr_match <= 1'b0;
        end
        else if (phase == sam_pkg::sam_addr & at_slot)
        begin
            addr_match <= mask_hit | gc_hit;
        end
    end

    // lost arbitration latch until next start or stop
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst | i_start_det | i_stop_det)
        begin
            lost <= 1'b0;
        end
        else if (i_arb_lost)
        begin
            lost <= 1'b1;
        end
    end

    // data bit drive changes after scl falls; lost arbitration or stop releases it at once
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst | i_arb_lost | i_stop_det)
        begin
            tx_low <= 1'b0;
        end
        else if (scl_fall)
        begin
            tx_low <= ~at_slot & in_byte & tx_en
                & ~shift_data_byte[7];
        end
    end

    // acknowledge window from the fall after the eighth rise to the ninth rise
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst | i_start_det | i_stop_det | scl_rise)
        begin
            ack_window <= 1'b0;
        end
        else if (scl_fall & at_slot)
        begin
            ack_window <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_sda_oe_n <= 1'b1;
            rdata <= 8'h00;
        end
        else
        begin
            o_sda_oe_n <= ~(tx_low | (ack_window & ack_val));
            rdata <= next_rdata;
        end
    end

    assign o_sda = 1'b0;
    assign o_sfr_rdata = rdata;
    assign o_addr_match = addr_match;
    assign o_ack_slot = ack_window;
    assign o_bit_count = bit_cnt;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_lost;
        i_arb_lost ##1 !tx_low;
    endsequence

    sequence s_stay_off;
        !tx_low [*2];
    endsequence

    a_mask_reset_value: assert property (
        $past(i_srst) |-> address_mask_register == `SAM_MASK_RST)
        else $error("mask reset value wrong");

    a_mask_ignore_bit: assert property (
        phase == sam_pkg::sam_addr && at_slot && !i_start_det
        && ((rx_addr ^ own_slave_address) & addr_compare_mask) == 7'h00
        |=> addr_match)
        else $error("masked address not matched");

    a_own_addr_miss: assert property (
        phase == sam_pkg::sam_addr && at_slot && !i_start_det
        && (rx_addr & addr_compare_mask)
        != (own_slave_address & addr_compare_mask)
        && !(general_call_enable && rx_addr == 7'h00)
        |=> !addr_match)
        else $error("foreign address matched");

    a_gcall_match: assert property (
        phase == sam_pkg::sam_addr && at_slot && !i_start_det
        && rx_addr == 7'h00
        |=> addr_match == ($past(mask_hit) | $past(general_call_enable)))
        else $error("general call match wrong");

    a_no_auto_ack: assert property (
        !hw_ack_enable && ack_window && !i_sw_ack && !tx_low
        |=> o_sda_oe_n)
        else $error("ack driven without software");

    a_hw_addr_ack: assert property (
        hw_ack_enable && ack_window && phase == sam_pkg::sam_addr
        && addr_match && !i_transmit && !tx_low |=> !o_sda_oe_n)
        else $error("matched address not acknowledged");

    a_data_write: assert property (
        data_wr |=> shift_data_byte == $past(i_sfr_wdata))
        else $error("data write lost");

    a_hold_done: assert property (
        $past(i_byte_done_flag) && !$past(data_wr) |-> $stable(shift_data_byte))
        else $error("data changed while byte done");

    a_msb_first: assert property (
        scl_fall && !at_slot && in_byte && tx_en && !i_stop_det
        |=> tx_low == !$past(shift_data_byte[7]))
        else $error("wrong bit driven");

    a_rx_shift_in: assert property (
        shift_en && !data_wr |=> shift_data_byte
        == {$past(shift_data_byte[6:0]), $past(sda_s)})
        else $error("received bit misplaced");

    a_tx_sample: assert property (
        shift_en && tx_en && !data_wr |=> shift_data_byte[0] == $past(sda_s))
        else $error("bus not sampled while sending");

    a_arb_release: assert property (
        s_lost |=> s_stay_off or ($past(i_start_det) || $past(i_stop_det)))
        else $error("drive kept after lost arbitration");

endmodule

// file: hdl/sam_defs.svh
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH

// register byte addresses
`define SAM_ADDR_DATA 8'hc2
`define SAM_ADDR_MASK 8'he7
`define SAM_ADDR_SLV 8'hd7

// reset values
`define SAM_DATA_RST 8'h00
`define SAM_MASK_RST 8'hfe
`define SAM_SLV_RST 8'h00

// field positions
`define SAM_HWACK_BIT 0
`define SAM_GC_BIT 0
`define SAM_ADDR_MSB 7
`define SAM_ADDR_LSB 1

// bit counts
`define SAM_ACK_SLOT 4'h8
`define SAM_BIT_ONE 4'h1

`endif

// file: hdl/sam_pkg.sv
package sam_pkg;

    // byte phase, gray coded along idle, addr, data
    typedef enum logic [1:0]
    {
        sam_idle = 2'b00,
        sam_addr = 2'b01,
        sam_data = 2'b11,
        sam_ignore = 2'b10
    } sam_phase_t;

endpackage

// file: hdl/sam_pin_sync.sv
`timescale 1ns/1ns
module sam_pin_sync (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [1:0] i_pin,
    output logic [1:0] o_level,
    output logic [1:0] o_rise,
    output logic [1:0] o_fall
);

    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_pin
            always_ff @(posedge i_core_clk)
            begin
                if (i_srst)
                begin
                    meta[g] <= 1'b1;
                    sync[g] <= 1'b1;
                    prev[g] <= 1'b1;
                end
                else
                begin
                    meta[g] <= i_pin[g];
                    sync[g] <= meta[g];
                    prev[g] <= sync[g];
                end
            end
            assign o_rise[g] = sync[g] & ~prev[g];
            assign o_fall[g] = ~sync[g] & prev[g];
        end
    endgenerate

    assign o_level = sync;

endmodule

// file: verif/sam_bus_peer.sv
`timescale 1ns/1ns
module sam_bus_peer (
    input wire logic i_core_clk,
    input wire logic i_wire_sda,
    output logic o_scl,
    output logic o_sda_rel
);
    // clock stands high and data is released between frames
    initial
    begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end

    // one byte plus ack slot, 160 ns a bit, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
        output logic ack);
        logic [8:0] out;
        logic [8:0] sh;
        out = {tx, 1'b1};
        sh = 9'h000;
        repeat (9)
        begin
            @(posedge i_core_clk) o_scl <= 1'b0;
            @(posedge i_core_clk) o_sda_rel <= out[8];
            out = out << 1;
            repeat (5) @(posedge i_core_clk);
            o_scl <= 1'b1;
            @(posedge i_core_clk);
            sh = {sh[7:0], i_wire_sda};
        end
        rx = sh[8:1];
        ack = !sh[0];
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ns
`include "sam_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk, srst, wr, en, bdone, start, tx, arb, swack;
    logic [7:0] addr, wdata, rdata, rx, d, slv, msk, a;
    logic scl, rel, o_sda, oe_n, match, ackslot, ack, m;
    logic [3:0] bitcnt;
    wire sda = rel & (oe_n | o_sda);
    int err_total, comparisons, cycles, seed;

    sam_addr_data_shift i_dut (.i_core_clk(clk), .i_srst(srst),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .o_sfr_rdata(rdata), .i_smb_enable(en), .i_byte_done_flag(bdone),
        .i_start_det(start), .i_stop_det(1'b0), .i_transmit(tx),
        .i_arb_lost(arb), .i_sw_ack(swack), .i_scl(scl), .i_sda(sda),
        .o_sda(o_sda), .o_sda_oe_n(oe_n), .o_addr_match(match),
        .o_ack_slot(ackslot), .o_bit_count(bitcnt));
    sam_bus_peer i_peer (.i_core_clk(clk), .i_wire_sda(sda), .o_scl(scl),
        .o_sda_rel(rel));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
    end

    task automatic wreg(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk) addr <= ad;
        wr <= 1'b1;
        wdata <= v;
        @(posedge clk) wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] ad, output logic [7:0] v);
        @(posedge clk) addr <= ad;
        repeat (2) @(posedge clk);
        #1 v = rdata;
    endtask

    // start pulse, optional lost arbitration, then one byte
    task automatic frame(input logic [7:0] b, input logic lose);
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        arb <= lose;
        @(posedge clk) arb <= 1'b0;
        repeat (2) @(posedge clk);
        i_peer.xfer(b, rx, ack);
        repeat (6) @(posedge clk);
    endtask

    function automatic logic hit(logic [7:0] ab, logic [7:0] s,
        logic [7:0] k);
        return (((ab[7:1] ^ s[7:1]) & k[7:1]) == 7'h00) ||
            (s[0] && ab[7:1] == 7'h00);
    endfunction

    initial
    begin
        {wr, en, bdone, start, tx, arb, swack} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        seed = 62;
        srst = 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        en <= 1'b1;
        rreg(`SAM_ADDR_DATA, d); `CHK(d, 8'h00)
        rreg(`SAM_ADDR_MASK, d); `CHK(d, 8'hfe)
        rreg(`SAM_ADDR_SLV, d); `CHK(d, 8'h00)
        rreg(8'h10, d); `CHK(d, 8'h00)
        $display("test reset values done");
        for (int i = 0; i < 12; i++)
        begin
            slv = 8'($random(seed));
            msk = 8'($random(seed));
            a = 8'($random(seed));
            if (i % 3 == 0)
                a[7:1] = (slv[7:1] & msk[7:1]) | (a[7:1] & ~msk[7:1]);
            if (i == 1 || i == 2)
            begin
                a[7:1] = 7'h00;
                slv = {7'h35, i == 1};
                msk = 8'hff;
            end
            wreg(`SAM_ADDR_SLV, slv);
            wreg(`SAM_ADDR_MASK, msk);
            @(posedge clk) swack <= 1'($random(seed));
            frame(a, 1'b0);
            m = hit(a, slv, msk);
            `CHK(ack, msk[0] ? m : swack)
            `CHK(match, m)
            `CHK(bitcnt, 4'h0)
            `CHK(ackslot, 1'b0)
            `CHK(o_sda, 1'b0)
        end
        $display("test address match done");
        wreg(`SAM_ADDR_SLV, 8'ha0);
        wreg(`SAM_ADDR_MASK, 8'hff);
        @(posedge clk) swack <= 1'b1;
        frame(8'ha1, 1'b0);
        d = 8'($random(seed));
        i_peer.xfer(d, rx, ack);
        `CHK(ack, 1'b1)
        @(posedge clk) bdone <= 1'b1;
        rreg(`SAM_ADDR_DATA, a); `CHK(a, d)
        frame(~d, 1'b0);
        rreg(`SAM_ADDR_DATA, a); `CHK(a, d)
        @(posedge clk) bdone <= 1'b0;
        wreg(`SAM_ADDR_DATA, 8'h33);
        @(posedge clk) bdone <= 1'b1;
        rreg(`SAM_ADDR_DATA, a); `CHK(a, d)
        wreg(`SAM_ADDR_DATA, 8'h33);
        rreg(`SAM_ADDR_DATA, a); `CHK(a, 8'h33)
        $display("test receive data done");
        @(posedge clk) bdone <= 1'b0;
        tx <= 1'b1;
        frame(8'hff, 1'b0);
        `CHK(rx, 8'h33)
        @(posedge clk) bdone <= 1'b1;
        rreg(`SAM_ADDR_DATA, a); `CHK(a, 8'h33)
        wreg(`SAM_ADDR_DATA, 8'h80);
        @(posedge clk) bdone <= 1'b0;
        frame(8'h2a, 1'b1);
        `CHK(rx, 8'h2a)
        @(posedge clk) bdone <= 1'b1;
        tx <= 1'b0;
        rreg(`SAM_ADDR_DATA, a); `CHK(a, 8'h2a)
        $display("test transmit and arbitration done");
        results();
    end
endmodule
